// ---- bench/arpm_host_model.sv ----
// Host model that strobes the port and reads words, bytes and serial bits.
`timescale 1ns/1ps
`default_nettype none
module arpm_host_model (
  input wire logic clock,
  input wire logic strap,
  input wire logic byteSel,
  input wire logic highFirst,
  input wire logic [15:0] busOut,
  input wire logic [15:0] busOe_n,
  output logic [15:0] busIn,
  output logic cs_n = 1'b1,
  output logic rd_n = 1'b1
);
  logic [15:0] host;
  // Pin levels: device where enabled, else straps, ground ties or toggling floating pins.
  always_comb begin
    host = strap ? {byteSel, byteSel & highFirst, 14'h0} : ~busOut;
    busIn = (busOut & ~busOe_n) | (host & busOe_n);
  end
  // Each strobe level is held long enough for the port's input synchronisers.
  task automatic level(input logic c, input logic r);
    @(posedge clock);
    cs_n <= c;
    rd_n <= r;
    repeat (6) @(posedge clock);
  endtask
  task automatic readWord(output logic [15:0] v);
    level(1'b0, 1'b0);
    @(negedge clock);
    v = busIn;
    level(1'b0, 1'b1);
    level(1'b1, 1'b1);
  endtask
  // Serial read takes one bit per read strobe pulse, most significant bit first.
  task automatic readSerial(output logic [15:0] v, output logic [15:0] w);
    level(1'b0, 1'b1);
    for (int i = 15; i >= 0; i--) begin
      @(negedge clock);
      v[i] = busIn[7];
      w[i] = busIn[8];
      level(1'b0, 1'b0);
      level(1'b0, 1'b1);
    end
    level(1'b1, 1'b1);
  endtask
endmodule
`default_nettype wire

// ---- bench/arpm_port_assertions.sv ----
// Checker of port timing against strobes, straps and reference select.
`timescale 1ns/1ps
`default_nettype none
module arpm_port_assertions (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic interface_select_strap,
  input wire logic chipSelect_n,
  input wire logic readStrobe_n,
  input wire logic [15:0] result_bus_in,
  input wire logic [15:0] result_bus_oe_n,
  input wire logic reference_select,
  input wire logic internalRefEnable,
  input wire logic [1:0] modeState
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Outputs must follow inputs that have stood still for several edges.
  AST_WORD_ON: assert property ((modeState==2'h0 && !chipSelect_n && !readStrobe_n)[*6]
    |-> result_bus_oe_n == 16'h0) else $error("word bus off");
  AST_BYTE_ON: assert property ((modeState==2'h1 && !chipSelect_n && !readStrobe_n)[*6]
    |-> result_bus_oe_n == 16'hff00) else $error("byte bus wrong");
  AST_BUS_OFF: assert property (chipSelect_n[*6] |-> result_bus_oe_n == 16'hffff)
    else $error("bus not released");
  AST_SER_PINS: assert property (modeState==2'h2 |-> (result_bus_oe_n | 16'h0180)==16'hffff)
    else $error("serial pins wrong");
  AST_REF_ON: assert property (reference_select[*4] |-> internalRefEnable)
    else $error("ref not on");
  AST_REF_OFF: assert property ((!reference_select)[*4] |-> !internalRefEnable)
    else $error("ref not off");
  AST_MODE_BYTE: assert property ((interface_select_strap && result_bus_in[15])[*6]
    |-> modeState == 2'h1) else $error("not byte mode");
  AST_MODE_SER: assert property ((interface_select_strap && !result_bus_in[15])[*6]
    |-> modeState == 2'h2) else $error("not serial mode");
  COV_WORD: cover property (modeState==2'h0 && result_bus_oe_n==16'h0);
  COV_BYTE: cover property (modeState==2'h1 && result_bus_oe_n==16'hff00);
  COV_SER: cover property (modeState==2'h2 && !result_bus_oe_n[7]);
endmodule
bind arpm_port arpm_port_assertions uChk (.clock, .rst_n, .interface_select_strap,
  .chipSelect_n, .readStrobe_n, .result_bus_in, .result_bus_oe_n, .reference_select,
  .internalRefEnable, .modeState);
`default_nettype wire

// ---- bench/arpm_port_tb_top.sv ----
// Testbench for the result port with a queue model of accepted words.
`timescale 1ns/1ps
`default_nettype none
module arpm_port_tb_top;
  logic clock, rst_n, resultValid, resultReady, resultDataB, strap, byteSel, highFirst;
  logic refSel, refOn, cs_n, rd_n;
  logic [15:0] resultData, busIn, busOut, busOe_n, v, a, b, e;
  logic [1:0] modeState;
  logic [15:0] q[$];
  int fail_count, n_compared, nAcc, cyc;
  integer seed;
  arpm_port uut (.clock, .rst_n, .resultData, .resultValid, .resultReady, .resultDataB,
    .interface_select_strap(strap), .chipSelect_n(cs_n), .readStrobe_n(rd_n),
    .result_bus_in(busIn), .result_bus_out(busOut), .result_bus_oe_n(busOe_n),
    .reference_select(refSel), .internalRefEnable(refOn), .modeState);
  arpm_host_model host (.clock, .strap, .byteSel, .highFirst, .busOut, .busOe_n, .busIn,
    .cs_n, .rd_n);
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // Records accepted words and cuts a hung run short.
  always @(posedge clock) begin
    resultDataB <= 1'($random(seed));
    if (rst_n && resultValid && resultReady) begin
      q.push_back(resultData);
      nAcc++;
    end
    cyc++;
    if (cyc > 20000) begin
      fail_count++;
      wrap_up;
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %h not %h", $time, got, exp);
    end
  endtask
  // Offers words one cycle each; a full buffer refuses them.
  task automatic put(input int n);
    repeat (n) begin
      @(posedge clock);
      resultData <= 16'($random(seed));
      resultValid <= 1'b1;
      @(posedge clock);
      resultValid <= 1'b0;
    end
  endtask
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    seed = 32'h0ac7;
    rst_n = 1'b0;
    resultValid = 1'b0;
    resultData = 16'h0;
    strap = 1'b0;
    byteSel = 1'b0;
    highFirst = 1'b0;
    refSel = 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    put(20);
    chk(16'(nAcc), 16'(arpm_pkg::FifoDepth));
    repeat (16) begin
      host.readWord(v);
      chk(v, q.pop_front());
    end
    $display("word test done");
    for (int r = 1; r >= 0; r--) begin
      @(posedge clock);
      refSel <= 1'(r);
      repeat (5) @(posedge clock);
      @(negedge clock);
      chk({15'h0, refOn}, 16'(r));
    end
    $display("reference test done");
    // Straps change only while no transfer runs.
    @(posedge clock);
    strap <= 1'b1;
    byteSel <= 1'b1;
    for (int h = 1; h >= 0; h--) begin
      highFirst <= 1'(h);
      put(1);
      repeat (6) @(posedge clock);
      host.readWord(a);
      host.readWord(b);
      chk(h ? {a[7:0], b[7:0]} : {b[7:0], a[7:0]}, q.pop_front());
    end
    $display("byte test done");
    @(posedge clock);
    byteSel <= 1'b0;
    highFirst <= 1'b0;
    put(2);
    repeat (6) @(posedge clock);
    // Output B carries the byte-swapped copy of the same word ahead of its own stream.
    repeat (2) begin
      host.readSerial(v, b);
      e = q.pop_front();
      chk(v, e);
      chk(b, {e[7:0], e[15:8]});
    end
    $display("serial test done");
    wrap_up;
  end
endmodule
`default_nettype wire

// ---- common/arpm_pkg.sv ----
// Package with the constants of the result output port multiplexer.
// Functional notes
// - Strap low: drive all sixteen bus pins with result bits while select and read low.
// - Word mode: bit 14 pin is three-state output of result bit 14.
// - Word mode: pins 13 down to 9 present matching result bits during read.
// - Strap high: bit 7 pin becomes serial output A; the code does so only in serial mode, in byte mode it drives the byte MSB.
// - Strap high: bit 8 pin becomes serial output B; the code does so only in serial mode, in byte mode the pin is not driven.
// - Byte mode: byte on lower eight pins, bit 7 pin is byte MSB.
// - Strap high with byte select low gives serial mode.
// - Strap high with byte select high gives parallel byte mode.
// - Byte mode: high byte first when order input is 1, else low first.
// - Reference select high enables internal reference, low disables it.
// - Parallel bus enabled only while select and read low, else high impedance.
// - Byte mode moves each 16-bit result in two read strobes.
package arpm_pkg;
  localparam int DataWidth = 16;
  localparam int ByteWidth = 8;
  localparam int FifoDepth = 16;
  localparam int SerialBitCountWidth = 4;
  localparam logic [3:0] SerialLastBit = 4'hf;
  localparam int BitSerialA = 7;
  localparam int BitSerialB = 8;
  localparam int BitHighByteFirst = 14;
  localparam int BitByteSelect = 15;
  localparam logic [15:0] BusOffAll = 16'hffff;
  localparam logic [15:0] ResultReset = 16'h0000;
  typedef enum logic [1:0] {
    ARPM_WORD,
    ARPM_BYTE,
    ARPM_SERIAL
  } arpm_mode_e;
endpackage

// ---- verilog/arpm_fifo.sv ----
// Small synchronous FIFO that buffers conversion results.
`timescale 1ns/1ps
`default_nettype none
module arpm_fifo #(
  parameter int Width = 16,
  parameter int Depth = 16
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [Width-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [Width-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  localparam int AddrWidth = $clog2(Depth);

  logic [Width-1:0] mem [Depth];
  logic [AddrWidth-1:0] wrPtr_q;
  logic [AddrWidth-1:0] rdPtr_q;
  logic [AddrWidth:0] count_q;
  logic doWrite;
  logic doRead;

  // Handshakes on both sides; full and empty come from the fill count.
  assign inReady = (count_q != Depth[AddrWidth:0]);
  assign outValid = (count_q != '0);
  assign doWrite = inValid && inReady;
  assign doRead = outValid && outReady;
  assign outData = mem[rdPtr_q];

  // Storage array is written only on an accepted word.
  always_ff @(posedge clock) begin
    if (doWrite) begin
      mem[wrPtr_q] <= inData;
    end
  end

  // Pointers and fill count.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (doWrite) begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (doRead) begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
      if (doWrite && !doRead) begin
        count_q <= count_q + 1'b1;
      end else if (doRead && !doWrite) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- verilog/arpm_port.sv ----
// Result output port: word, byte and dual serial presentation of conversion results.
`timescale 1ns/1ps
`default_nettype none
module arpm_port (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [15:0] resultData,
  input wire logic resultValid,
  output logic resultReady,
  input wire logic resultDataB,
  input wire logic interface_select_strap,
  input wire logic chipSelect_n,
  input wire logic readStrobe_n,
  input wire logic [15:0] result_bus_in,
  output logic [15:0] result_bus_out,
  output logic [15:0] result_bus_oe_n,
  input wire logic reference_select,
  output logic internalRefEnable,
  output logic [1:0] modeState
);
  // Pin synchronisers, two flops each.
  logic [15:0] busIn_s1_q;
  logic [15:0] busIn_q;
  logic strap_s1_q;
  logic strap_q;
  logic cs_s1_q;
  logic cs_n_q;
  logic rd_s1_q;
  logic rd_n_q;
  logic ref_s1_q;
  logic ref_q;
  logic rdPrev_n_q;
  logic csPrev_n_q;

  // Mode and transfer state.
  arpm_pkg::arpm_mode_e mode_q;
  logic [15:0] word_q;
  logic [15:0] wordB_q;
  logic secondByte_q;
  logic [3:0] bitCount_q;
  logic shiftActive_q;
  logic [15:0] busOut_q;
  logic [15:0] busOe_n_q;
  logic refEn_q;

  // Fifo side.
  logic [15:0] fifoData;
  logic fifoValid;
  logic fifoPop;
  logic fifoInReady;

  // Decoded strobes.
  logic readActive;
  logic rdFall;
  logic rdRise;
  logic csFall;
  logic csRise;
  logic byteOrderHigh;
  logic [7:0] byteNow;

  arpm_fifo #(
    .Width(arpm_pkg::DataWidth),
    .Depth(arpm_pkg::FifoDepth)
  ) uFifo (
    .clock(clock),
    .rst_n(rst_n),
    .inData(resultData),
    .inValid(resultValid),
    .inReady(fifoInReady),
    .outData(fifoData),
    .outValid(fifoValid),
    .outReady(fifoPop)
  );

  // Synchronise every pin input before use.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      busIn_s1_q <= '0;
      busIn_q <= '0;
      strap_s1_q <= 1'b0;
      strap_q <= 1'b0;
      cs_s1_q <= 1'b1;
      cs_n_q <= 1'b1;
      rd_s1_q <= 1'b1;
      rd_n_q <= 1'b1;
      ref_s1_q <= 1'b0;
      ref_q <= 1'b0;
      rdPrev_n_q <= 1'b1;
      csPrev_n_q <= 1'b1;
    end else begin
      busIn_s1_q <= result_bus_in;
      busIn_q <= busIn_s1_q;
      strap_s1_q <= interface_select_strap;
      strap_q <= strap_s1_q;
      cs_s1_q <= chipSelect_n;
      cs_n_q <= cs_s1_q;
      rd_s1_q <= readStrobe_n;
      rd_n_q <= rd_s1_q;
      ref_s1_q <= reference_select;
      ref_q <= ref_s1_q;
      rdPrev_n_q <= rd_n_q;
      csPrev_n_q <= cs_n_q;
    end
  end

  // Strobe edges and the current byte in byte mode.
  assign readActive = !cs_n_q && !rd_n_q;
  assign rdFall = rdPrev_n_q && !rd_n_q && !cs_n_q;
  assign rdRise = !rdPrev_n_q && rd_n_q;
  assign csFall = csPrev_n_q && !cs_n_q;
  assign csRise = !csPrev_n_q && cs_n_q;
  assign byteOrderHigh = busIn_q[arpm_pkg::BitHighByteFirst];
  assign byteNow = (byteOrderHigh ^ secondByte_q) ? word_q[15:8] : word_q[7:0];

  // A new word is taken from the buffer after a word read, after the second byte, or on select release in serial mode.
  assign fifoPop = fifoValid && (
    (mode_q == arpm_pkg::ARPM_WORD && rdRise) ||
    (mode_q == arpm_pkg::ARPM_BYTE && rdRise && secondByte_q) ||
    (mode_q == arpm_pkg::ARPM_SERIAL && csRise));
  assign resultReady = fifoInReady;

  // Mode decode from the straps; the byte select shares the bit 15 pin.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      mode_q <= arpm_pkg::ARPM_WORD;
    end else if (!strap_q) begin
      mode_q <= arpm_pkg::ARPM_WORD;
    end else if (busIn_q[arpm_pkg::BitByteSelect]) begin
      mode_q <= arpm_pkg::ARPM_BYTE;
    end else begin
      mode_q <= arpm_pkg::ARPM_SERIAL;
    end
  end

  // Holding words: refreshed from the buffer head while no transfer is open.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      word_q <= arpm_pkg::ResultReset;
      wordB_q <= arpm_pkg::ResultReset;
    end else if (cs_n_q || fifoPop) begin
      word_q <= fifoValid ? fifoData : word_q;
      wordB_q <= fifoValid ? {fifoData[7:0], fifoData[15:8]} : wordB_q;
    end else if (mode_q == arpm_pkg::ARPM_SERIAL && rdRise && shiftActive_q) begin
      word_q <= {word_q[14:0], 1'b0};
      wordB_q <= {wordB_q[14:0], resultDataB};
    end
  end

  // Byte phase: two read strobes move one 16-bit result.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      secondByte_q <= 1'b0;
    end else if (mode_q != arpm_pkg::ARPM_BYTE) begin
      secondByte_q <= 1'b0;
    end else if (rdRise && !cs_n_q) begin
      secondByte_q <= !secondByte_q;
    end
  end

  // Serial bit counter; select falling edge presents the MSB.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      bitCount_q <= '0;
      shiftActive_q <= 1'b0;
    end else if (csFall) begin
      bitCount_q <= '0;
      shiftActive_q <= 1'b1;
    end else if (cs_n_q) begin
      shiftActive_q <= 1'b0;
    end else if (rdRise && shiftActive_q) begin
      bitCount_q <= bitCount_q + 1'b1;
      if (bitCount_q == arpm_pkg::SerialLastBit) begin
        shiftActive_q <= 1'b0;
      end
    end
  end

  // Pin drive per mode; enables are low while the pin is driven.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      busOut_q <= '0;
      busOe_n_q <= arpm_pkg::BusOffAll;
    end else begin
      busOut_q <= '0;
      busOe_n_q <= arpm_pkg::BusOffAll;
      unique case (mode_q)
        arpm_pkg::ARPM_WORD: begin
          if (readActive) begin
            busOut_q <= word_q;
            busOe_n_q <= '0;
          end
        end
        arpm_pkg::ARPM_BYTE: begin
          if (readActive) begin
            busOut_q[7:0] <= byteNow;
            busOe_n_q[7:0] <= '0;
          end
        end
        arpm_pkg::ARPM_SERIAL: begin
          if (!cs_n_q) begin
            busOut_q[arpm_pkg::BitSerialA] <= word_q[15];
            busOut_q[arpm_pkg::BitSerialB] <= wordB_q[15];
            busOe_n_q[arpm_pkg::BitSerialA] <= 1'b0;
            busOe_n_q[arpm_pkg::BitSerialB] <= 1'b0;
          end
        end
        default: begin
          busOut_q <= '0;
        end
      endcase
    end
  end

  // Reference source selection.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      refEn_q <= 1'b0;
    end else begin
      refEn_q <= ref_q;
    end
  end

  assign result_bus_out = busOut_q;
  assign result_bus_oe_n = busOe_n_q;
  assign internalRefEnable = refEn_q;
  assign modeState = mode_q;
endmodule
`default_nettype wire
